// ---- design/lsp_exec.sv ----
// Execution unit for load/store, pointer, flag, jump, call and bank instructions
`timescale 1ns/100ps
module lsp_exec #(
  parameter int unsigned RAM_AW = lsp_pkg::MEM_AW_MIN
) (
  input  wire logic                     ref_clk_i,
  input  wire logic                     rst_n_i,
  output logic [lsp_pkg::PC_W-1:0]      rom_addr_o,
  input  wire logic [7:0]               rom_data_i,
  output logic [7:0]                    port45_o,
  output logic                          port45_stb_o,
  output logic [lsp_pkg::PC_W-1:0]      pc_o,
  output logic [7:0]                    stack_ptr_o,
  output logic [3:0]                    main_work_reg_o,
  output logic [3:0]                    ext_reg_o,
  output logic [7:0]                    primary_pointer_o,
  output logic [7:0]                    aux_pointer_o,
  output logic                          carry_flag_o,
  output logic                          zero_flag_o,
  output logic [15:0]                   user_flags_o,
  output logic                          mem_bank_o,
  output logic                          reg_bank_o,
  output logic                          instr_done_o,
  output logic                          foreign_op_o
);
  import lsp_pkg::*;

  // ----------------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------------
  if (RAM_AW < MEM_AW_MIN) begin : g_aw_chk
    $error("RAM_AW too small for bank plus 8-bit address");
  end

  lsp_core_st_t q;
  lsp_core_st_t d;
  lsp_mem_if #(.AW(RAM_AW), .DW(NIB_W)) mem ();

  logic [7:0]      opc;
  logic [7:0]      arg;
  logic [7:0]      ptr8;
  logic [7:0]      mem_a8;
  logic            mem_stk;
  logic [3:0]      step_val;
  logic [3:0]      step_res;
  logic            step_zero;
  logic            step_down;
  logic [7:0]      push_off;
  logic [3:0]      push_nib;
  logic [PC_W-1:0] ret_pc;
  logic [PC_W-1:0] new_pc;
  logic            last;

  // ----------------------------------------------------------------------
  // Decode: opcode straight from ROM in the first cycle, latched later
  // ----------------------------------------------------------------------
  logic is_ind, is_sae, is_store, is_rom_table_read, is_rom_table_to_port, is_ldz, is_sfb, is_rfb;
  logic is_jmp, is_jump_by_table_regs, is_cal, is_czp, is_bank, is_xpair, is_stp1, is_pfx;
  logic two_byte, two_cyc, known, is_ext, is_call;

  assign opc      = (q.st == ST_OP) ? rom_data_i : q.op;
  assign arg      = rom_data_i;
  assign is_ind   = (opc[7:5] == 3'b010) && opc[3] && (!opc[4] || opc[0]);
  assign is_sae   = (opc == OP_SAE);
  assign is_store = (opc == OP_STORE);
  assign is_rom_table_read  = (opc == OP_ROM_TABLE_READ);
  assign is_rom_table_to_port = (opc == OP_ROM_TABLE_TO_PORT);
  assign is_jump_by_table_regs  = (opc == OP_JUMP_BY_TABLE_REGS);
  assign is_bank  = (opc == OP_BANK);
  assign is_ldz   = (opc[7:4] == OPH_LDZ);
  assign is_sfb   = (opc[7:4] == OPH_SFB);
  assign is_rfb   = (opc[7:4] == OPH_RFB);
  assign is_jmp   = (opc[7:4] == OPH_JMP);
  assign is_czp   = (opc[7:4] == OPH_CZP);
  assign is_pfx   = (opc[7:4] == OPH_PFX);
  assign is_cal   = (opc[7:3] == OP5_CAL);
  assign is_xpair = (opc[7:2] == OP_XPAIR);
  assign is_stp1  = ((opc[7:4] == OPH_INC) || (opc[7:4] == OPH_DEC))
                    && (opc[3:2] == 2'b00) && opc[0];
  assign is_call  = is_cal || is_czp;
  assign two_byte = is_pfx || is_jmp || is_cal;
  assign two_cyc  = (is_ind && opc[0]) || is_rom_table_read || is_rom_table_to_port || is_sae || is_czp;
  assign known    = is_ind || is_sae || is_store || is_rom_table_read || is_rom_table_to_port || is_ldz
                    || is_sfb || is_rfb || is_jmp || is_jump_by_table_regs || is_cal || is_czp
                    || is_bank || is_xpair || is_stp1 || is_pfx;
  // Transfer group shares the 1100_1111 prefix with pair loads of operand F_
  assign is_ext   = (q.op[3:0] == EXT_LO) && (arg[7:4] inside {SUB_LHI, SUB_LLI,
                    SUB_TAH, SUB_THA, SUB_TAL, SUB_TLA, SUB_TAX, SUB_TXA, SUB_TAY, SUB_TYA});

  // Pointer select: opcode bit 1 picks the auxiliary pair
  // Plain store and other one-pointer forms always use the primary pair
  assign ptr8      = (is_ind && opc[1]) ? {q.aux_ptr_high, q.aux_ptr_low} : {q.primary_ptr_high, q.primary_ptr_low};
  assign step_val  = opc[1] ? q.aux_ptr_low : q.primary_ptr_low;
  assign step_down = is_ind ? opc[4] : opc[5];

  lsp_nib_step #(.W(NIB_W)) u_step (
    .val_i  (step_val),
    .down_i (step_down),
    .res_o  (step_res),
    .zero_o (step_zero)
  );

  // ----------------------------------------------------------------------
  // Call frame: one nibble per phase, flags nibble first, lowest address last
  // ----------------------------------------------------------------------
  assign ret_pc   = q.pc + (is_cal ? PC_W'(2) : PC_W'(1));
  assign push_off = {6'b0, q.st != ST_OP, q.ph} + 8'h01;
  always_comb begin
    case (push_off[2:0])
      3'd1:    push_nib = {q.cf, q.zf, ret_pc[13:12]};
      3'd2:    push_nib = ret_pc[11:8];
      3'd3:    push_nib = ret_pc[7:4];
      default: push_nib = ret_pc[3:0];
    endcase
  end

  // ----------------------------------------------------------------------
  // Sequencer: each instruction cycle is a read phase then a write phase
  // ----------------------------------------------------------------------
  always_comb begin
    d          = q;
    d.ph       = ~q.ph;
    d.done     = 1'b0;
    d.foreign  = 1'b0;
    d.port_stb = 1'b0;
    mem_a8     = ptr8;
    mem_stk    = 1'b0;
    mem.we     = 1'b0;
    mem.wdata  = q.ac;
    rom_addr_o = (q.st == ST_ARG) ? q.pc + PC_W'(1) : q.pc;
    new_pc     = q.pc + PC_W'(1);
    last       = 1'b0;
    // Calls store one frame nibble on every phase of both cycles
    if (is_call && !(q.st == ST_OP && !known)) begin
      mem_a8    = q.sp - push_off;
      mem_stk   = 1'b1;
      mem.we    = 1'b1;
      mem.wdata = push_nib;
    end
    if (is_sae) begin
      mem_a8 = {q.primary_ptr_high, q.primary_ptr_low[3:1], q.st == ST_X2};
    end
    case (q.st)
      ST_OP: begin
        if (!q.ph) begin
          d.op = rom_data_i;
        end else begin
          if (is_ind) begin
            d.ac = mem.rdata;
            mem.we = is_ind && opc[2];
          end
          if (is_store || is_sae) begin
            mem.we = 1'b1;
          end
          if (is_ldz) begin
            d.primary_ptr_high = 4'h0;
            d.primary_ptr_low = opc[3:0];
          end
          if (is_sfb) begin
            d.fl[opc[3:0]] = 1'b1;
          end
          if (is_rfb) begin
            d.fl[opc[3:0]] = 1'b0;
          end
          if (is_stp1 && opc[1]) begin
            d.aux_ptr_low = step_res;
          end else if (is_stp1) begin
            d.primary_ptr_low = step_res;
          end
          if (is_xpair) begin
            case (opc[1:0])
              2'b00:   begin d.primary_ptr_high = q.ac; d.ac = q.primary_ptr_high; end
              2'b01:   begin d.primary_ptr_low = q.ac; d.ac = q.primary_ptr_low; end
              2'b10:   begin d.aux_ptr_high = q.ac; d.ac = q.aux_ptr_high; end
              default: begin d.aux_ptr_low = q.ac; d.ac = q.aux_ptr_low; end
            endcase
          end
          if (is_jump_by_table_regs) begin
            new_pc = {q.pc[13:8], q.e, q.ac};
          end
          if (!known) begin
            d.foreign = 1'b1;
          end
          if (known && two_byte) begin
            d.st = ST_ARG;
          end else if (known && two_cyc) begin
            d.st = ST_X2;
          end else begin
            last = 1'b1;
          end
        end
      end
      ST_ARG: begin
        if (is_pfx && !is_ext && arg[7:4] == SUB_EXCHANGE_DIRECT) begin
          mem_a8 = {q.op[3:0], arg[3:0]};
        end
        if (!q.ph) begin
          d.arg = arg;
        end else begin
          last   = 1'b1;
          new_pc = q.pc + PC_W'(2);
          if (is_jmp && q.bank) begin
            new_pc = {q.pc[13:12] + 2'b01, q.op[3:0], arg};
          end else if (is_jmp) begin
            new_pc = {q.pc[13:12], q.op[3:0], arg};
          end
          if (is_cal) begin
            new_pc = {3'b000, q.op[2:0], arg};
            d.sp   = q.sp - SP_CALL_DEC;
          end
          if (is_pfx && is_ext) begin
            case (arg[7:4])
              SUB_LHI: d.primary_ptr_high = arg[3:0];
              SUB_LLI: d.primary_ptr_low = arg[3:0];
              SUB_TAH: d.primary_ptr_high = q.ac;
              SUB_THA: d.ac  = q.primary_ptr_high;
              SUB_TAL: d.primary_ptr_low = q.ac;
              SUB_TLA: d.ac  = q.primary_ptr_low;
              SUB_TAX: d.aux_ptr_high = q.ac;
              SUB_TXA: d.ac  = q.aux_ptr_high;
              SUB_TAY: d.aux_ptr_low = q.ac;
              default: d.ac  = q.aux_ptr_low;
            endcase
          end else if (is_pfx) begin
            case (arg[7:4])
              SUB_LOAD_PRIMARY_PTR_IMM: begin d.primary_ptr_high = q.op[3:0]; d.primary_ptr_low = arg[3:0]; end
              SUB_LOAD_AUX_PTR_IMM: begin d.aux_ptr_high = q.op[3:0]; d.aux_ptr_low = arg[3:0]; end
              SUB_LOAD_PAIR_IMMEDIATE: begin d.e = q.op[3:0]; d.ac = arg[3:0]; end
              SUB_EXCHANGE_DIRECT: begin
                d.ac   = mem.rdata;
                mem.we = 1'b1;
              end
              default:  d.foreign = 1'b1;
            endcase
          end
        end
      end
      ST_X2: begin
        if (is_rom_table_read || is_rom_table_to_port) begin
          rom_addr_o = {q.pc[13:8], q.e, q.ac};
        end
        if (q.ph) begin
          last = 1'b1;
          if (is_rom_table_read) begin
            {d.e, d.ac} = rom_data_i;
          end
          if (is_rom_table_to_port) begin
            d.port     = rom_data_i;
            d.port_stb = 1'b1;
          end
          if (is_sae) begin
            mem.we    = 1'b1;
            mem.wdata = q.e;
          end
          if (is_ind && opc[1]) begin
            d.aux_ptr_low = step_res;
          end else if (is_ind) begin
            d.primary_ptr_low = step_res;
          end
          if (is_ind) begin
            d.zf = step_zero;
          end
          if (is_czp) begin
            new_pc = {8'h00, q.op[3:0], 2'b00};
            d.sp   = q.sp - SP_CALL_DEC;
          end
        end
      end
      default: d.st = ST_OP;
    endcase
    // Instruction end: bank choice lives for exactly one following instruction
    if (last) begin
      d.st   = ST_OP;
      d.pc   = new_pc;
      d.done = 1'b1;
      d.bank = (q.st == ST_OP) && is_bank;
    end
  end

  // Stack frames always sit in bank 0; other accesses follow the bank choice
  assign mem.addr = RAM_AW'({q.bank && !mem_stk, mem_a8});

  // State register: carry flag is never written here, zero flag only by steps
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      q <= CORE_RST;
    end else begin
      q <= d;
    end
  end

  lsp_nib_ram #(.AW(RAM_AW), .DW(NIB_W)) u_ram (
    .ref_clk_i (ref_clk_i),
    .mem       (mem)
  );

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign port45_o          = q.port;
  assign port45_stb_o      = q.port_stb;
  assign pc_o              = q.pc;
  assign stack_ptr_o       = q.sp;
  assign main_work_reg_o   = q.ac;
  assign ext_reg_o         = q.e;
  assign primary_pointer_o = {q.primary_ptr_high, q.primary_ptr_low};
  assign aux_pointer_o     = {q.aux_ptr_high, q.aux_ptr_low};
  assign carry_flag_o      = q.cf;
  assign zero_flag_o       = q.zf;
  assign user_flags_o      = q.fl;
  assign mem_bank_o        = q.bank;
  assign reg_bank_o        = q.bank;
  assign instr_done_o      = q.done;
  assign foreign_op_o      = q.foreign;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_fetch(logic [7:0] mask, logic [7:0] val);
    q.st == ST_OP && !q.ph && ((rom_data_i & mask) == val);
  endsequence

  AST_XA_ONE_CYCLE: assert property (
    s_fetch(8'hfd, 8'h4c) |-> ##1 (mem.we && mem.wdata == q.ac) ##1 (q.done && q.st == ST_OP))
    else $error("plain exchange did not finish in one cycle");
  AST_LA_INC_TWO: assert property (
    s_fetch(8'hfd, 8'h49) |-> ##1 !q.done ##1 !q.done ##1 !q.done ##1 q.done)
    else $error("load with increment did not take two cycles");
  AST_STEP_ZF: assert property (
    (q.done && q.op[7:5] == 3'b010 && q.op[3] && q.op[0])
      |-> q.zf == ((q.op[1] ? q.aux_ptr_low : q.primary_ptr_low) == 4'h0))
    else $error("zero flag not taken from stepped pointer");
  AST_LOAD_PAIR_IMMEDIATE: assert property (
    (q.done && q.op[7:4] == OPH_PFX && q.op[3:0] != EXT_LO && q.arg[7:4] == SUB_LOAD_PAIR_IMMEDIATE)
      |-> (q.e == q.op[3:0] && q.ac == q.arg[3:0]))
    else $error("immediate pair-load placed nibbles wrongly");
  AST_LDZ: assert property (
    (q.done && q.op[7:4] == OPH_LDZ) |-> (q.primary_ptr_high == 4'h0 && q.primary_ptr_low == q.op[3:0]))
    else $error("pointer zero-high load wrong");
  AST_FLAG_SET: assert property (
    (q.done && q.op[7:4] == OPH_SFB) |-> (q.fl[q.op[3:0]] && $past(q.st) == ST_OP))
    else $error("user flag not set in one cycle");
  AST_FLAG_CLR: assert property (
    (q.done && q.op[7:4] == OPH_RFB) |-> !q.fl[q.op[3:0]])
    else $error("user flag not cleared");
  AST_JMP_BANK: assert property (
    (q.done && q.op[7:4] == OPH_JMP && !$past(q.bank))
      |-> (q.pc == {$past(q.pc[13:12]), q.op[3:0], q.arg}))
    else $error("jump changed bank bits or target wrong");
  AST_CALL_SP: assert property (
    (q.done && q.op[7:3] == OP5_CAL) |-> (q.sp == $past(q.sp) - SP_CALL_DEC && q.pc[13:11] == 3'b000))
    else $error("long call stack or target wrong");
  AST_SAE_EVEN: assert property (
    (q.st == ST_OP && q.ph && is_sae) |-> (mem.we && mem.addr[0] == 1'b0) ##2 (mem.we && mem.addr[0]))
    else $error("pair store not even-aligned");
endmodule

// ---- design/lsp_pkg.sv ----
// Constants, opcodes and state types for the load/store/pointer/jump execution unit
//
// How it works
// - Store-pair writes accumulator, then extension register at the next nibble.
// - Opcode select bit picks the primary pointer when 0, auxiliary when 1.
// - Load-increment loads accumulator, then adds one to pointer low nibble; two cycles.
// - Decrement load and exchange forms subtract one from pointer low nibble afterwards.
// - Stepping loads and exchanges set the zero flag from the new pointer low nibble; one-cycle pointer steps leave it.
// - Plain exchange swaps accumulator and pointed nibble in one cycle.
// - Direct exchange swaps accumulator with the nibble at an 8-bit operand address.
// - Immediate pair-load puts operand high nibble in extension, low in accumulator.
// - Table read fetches ROM at upper PC bits plus extension and accumulator.
// - Table-to-port variant drives the fetched byte to ports 4 and 5.
// - One-cycle load clears pointer high nibble and loads low from opcode.
// - Two-byte loads set only the high or only the low primary pointer nibble.
// - Two-byte pair loads fill primary or auxiliary pointer from an 8-bit operand.
// - Set and clear opcodes change one of sixteen user flags in one cycle.
// - Jump loads PC bits 11..0 and keeps bank bits 13..12; two cycles.
// - A jump right after a bank change alters the PC bank bits.
// - Register jump keeps PC 13..8, takes extension then accumulator below.
// - Long call clears PC 13..11, pushes flags and return in four nibbles.
// - Short call targets page 0 bank 0 with bits 5..2 from the opcode.
// - Bank change switches memory and register bank for the next instruction.
// - Pair access through the primary pointer starts on an even address.
package lsp_pkg;

  // ----------------------------------------------------------------------
  // Widths, reset values and timing
  // ----------------------------------------------------------------------
  localparam int unsigned NIB_W      = 4;
  localparam int unsigned PC_W       = 14;
  localparam int unsigned MEM_AW_MIN = 9;           // bank bit + 8-bit address
  localparam logic [7:0]  SP_RST     = 8'h00;
  localparam logic [7:0]  SP_CALL_DEC = 8'h04;      // four nibbles per call frame
  localparam int unsigned CYCLE_NS   = 100;         // instruction cycle length
  localparam int unsigned CLK_NS     = 100;         // ref_clk_i period
  localparam int unsigned TICKS_PER_CYCLE = 2;      // read phase, write phase
  localparam int unsigned CLK_PER_PHASE = (CYCLE_NS / TICKS_PER_CYCLE + CLK_NS - 1) / CLK_NS;

  // ----------------------------------------------------------------------
  // Opcodes (full bytes, upper nibbles, 5- and 6-bit prefixes, prefix low nibble)
  // ----------------------------------------------------------------------
  localparam logic [7:0] OP_STORE = 8'h47;
  localparam logic [7:0] OP_SAE   = 8'h5e;
  localparam logic [7:0] OP_ROM_TABLE_READ  = 8'h5a;
  localparam logic [7:0] OP_ROM_TABLE_TO_PORT = 8'h58;
  localparam logic [7:0] OP_JUMP_BY_TABLE_REGS  = 8'h26;
  localparam logic [7:0] OP_BANK  = 8'h1b;
  localparam logic [5:0] OP_XPAIR = 6'h10;          // 0100_00rr: exchange with pointer nibble
  localparam logic [3:0] OPH_LDZ  = 4'h6;
  localparam logic [3:0] OPH_SFB  = 4'h7;
  localparam logic [3:0] OPH_RFB  = 4'h3;
  localparam logic [3:0] OPH_INC  = 4'h1;
  localparam logic [3:0] OPH_DEC  = 4'h2;
  localparam logic [3:0] OPH_PFX  = 4'hc;
  localparam logic [3:0] OPH_JMP  = 4'he;
  localparam logic [3:0] OPH_CZP  = 4'ha;
  localparam logic [4:0] OP5_CAL  = 5'h0a;
  localparam logic [3:0] EXT_LO   = 4'hf;           // prefix low nibble of the transfer group

  // Second-byte sub-codes after the 1100 prefix
  localparam logic [3:0] SUB_LOAD_PRIMARY_PTR_IMM = 4'h0;
  localparam logic [3:0] SUB_LOAD_AUX_PTR_IMM = 4'h4;
  localparam logic [3:0] SUB_LOAD_PAIR_IMMEDIATE = 4'h6;
  localparam logic [3:0] SUB_EXCHANGE_DIRECT = 4'h8;
  localparam logic [3:0] SUB_LHI  = 4'h1;
  localparam logic [3:0] SUB_LLI  = 4'h2;
  localparam logic [3:0] SUB_TAH  = 4'h3;
  localparam logic [3:0] SUB_THA  = 4'h5;
  localparam logic [3:0] SUB_TAL  = 4'h7;
  localparam logic [3:0] SUB_TLA  = 4'h9;
  localparam logic [3:0] SUB_TAX  = 4'ha;
  localparam logic [3:0] SUB_TXA  = 4'hb;
  localparam logic [3:0] SUB_TAY  = 4'hd;
  localparam logic [3:0] SUB_TYA  = 4'he;

  // ----------------------------------------------------------------------
  // Sequencer state and register image
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_OP  = 2'b00,
    ST_ARG = 2'b01,
    ST_X2  = 2'b10
  } lsp_state_t;

  typedef struct packed {
    lsp_state_t        st;
    logic              ph;
    logic [7:0]        op;
    logic [7:0]        arg;
    logic [PC_W-1:0]   pc;
    logic [7:0]        sp;
    logic [3:0]        ac;
    logic [3:0]        e;
    logic [3:0]        primary_ptr_high;
    logic [3:0]        primary_ptr_low;
    logic [3:0]        aux_ptr_high;
    logic [3:0]        aux_ptr_low;
    logic              cf;
    logic              zf;
    logic [15:0]       fl;
    logic              bank;
    logic [7:0]        port;
    logic              port_stb;
    logic              done;
    logic              foreign;
  } lsp_core_st_t;

  localparam lsp_core_st_t CORE_RST = '{st: ST_OP, sp: SP_RST, default: '0};

endpackage

// ---- design/lsp_mem_if.sv ----
// Nibble memory port between the execution unit and its data memory
`timescale 1ns/100ps
interface lsp_mem_if #(
  parameter int unsigned AW = 9,
  parameter int unsigned DW = 4
) ();
  logic [AW-1:0] addr;
  logic          we;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;

  modport master (output addr, output we, output wdata, input rdata);
  modport ram    (input addr, input we, input wdata, output rdata);
endinterface

// ---- design/lsp_nib_ram.sv ----
// Nibble-wide data memory with registered read data
`timescale 1ns/100ps
module lsp_nib_ram #(
  parameter int unsigned AW = lsp_pkg::MEM_AW_MIN,
  parameter int unsigned DW = lsp_pkg::NIB_W
) (
  input  wire logic ref_clk_i,
  lsp_mem_if.ram    mem
);
  logic [DW-1:0] store_q [2**AW];
  logic [DW-1:0] rdata_q;

  // Read returns the old word on a same-address write; the exchange uses the word read a phase earlier
  always_ff @(posedge ref_clk_i) begin
    if (mem.we) begin
      store_q[mem.addr] <= mem.wdata;
    end
    rdata_q <= store_q[mem.addr];
  end

  assign mem.rdata = rdata_q;
endmodule

// ---- design/lsp_nib_step.sv ----
// Pointer nibble step: add or subtract one, with zero detect
`timescale 1ns/100ps
module lsp_nib_step #(
  parameter int unsigned W = lsp_pkg::NIB_W
) (
  input  wire logic [W-1:0] val_i,
  input  wire logic         down_i,
  output logic [W-1:0]      res_o,
  output logic              zero_o
);
  // Wraps within the nibble; the high nibble is never carried into
  assign res_o  = down_i ? val_i - W'(1) : val_i + W'(1);
  assign zero_o = (res_o == '0);
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the load/store/pointer/jump execution unit
`timescale 1ns/100ps
module tb;
  import lsp_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [PC_W-1:0] ra, pc;
  logic [7:0] rd, p45, sp, hl, xy;
  logic [3:0] ac, e;
  logic [15:0] uf;
  logic cf, zf, stb, mb, rb, done, fo;
  logic [7:0] rom [0:16383];
  logic [7:0] prog [32] = '{8'hc3, 8'h05, 8'hc1, 8'h4a, 8'h6b, 8'hc9, 8'h67, 8'h47,
    8'hc0, 8'h62, 8'h4c, 8'h49, 8'h61, 8'h47, 8'h59, 8'hc1, 8'h0a, 8'hc0, 8'h65, 8'h47,
    8'hc0, 8'h60, 8'h4a, 8'hc6, 8'h60, 8'h5a, 8'h58, 8'h75, 8'h35, 8'hc7, 8'h60, 8'h26};
  int bad_count = 0;
  int comparisons = 0;
  // ROM answers in the same clock, so it cannot be driven by a registered process
  assign rd = rom[ra];
  lsp_exec lsp_exec_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .rom_addr_o(ra),
    .rom_data_i(rd), .port45_o(p45), .port45_stb_o(stb), .pc_o(pc), .stack_ptr_o(sp),
    .main_work_reg_o(ac), .ext_reg_o(e), .primary_pointer_o(hl), .aux_pointer_o(xy),
    .carry_flag_o(cf), .zero_flag_o(zf), .user_flags_o(uf), .mem_bank_o(mb),
    .reg_bank_o(rb), .instr_done_o(done), .foreign_op_o(fo));
  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Bounded wait for the next completion pulse, seen once settled
  task automatic nxt();
    int n;
    n = 0;
    do begin
      @(negedge ref_clk_i);
      n++;
    end while (done !== 1'b1 && n < 20);
    if (done !== 1'b1) begin
      bad_count++;
      $display("BAD t=%0t no completion", $time);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_ptr();
    nxt(); chk(hl, 8'h35);
    nxt(); chk(xy, 8'h1a);
    nxt(); chk(hl, 8'h0b);
  endtask
  task automatic t_mem();
    nxt(); chk({e, ac}, 8'h97);
    nxt(); nxt();
    nxt(); chk({ac, hl}, 12'h70b);
    nxt(); chk({zf, ac, hl}, 13'h020c);
    nxt(); nxt();
    nxt(); chk({zf, ac, hl}, 13'h1200);
  endtask
  task automatic t_aux();
    repeat (4) nxt();
    nxt(); chk(ac, 4'h5);
  endtask
  task automatic t_tab();
    nxt(); nxt(); chk({e, ac}, 8'hb5);
    nxt(); chk({stb, p45}, 9'h13c);
  endtask
  task automatic t_flag();
    nxt(); chk(uf, 16'h0020);
    nxt(); chk(uf, 16'h0000);
  endtask
  task automatic t_jump();
    nxt(); nxt(); chk(pc, 14'h0070);
    nxt(); chk(pc, 14'h0100);
    nxt(); chk({sp, pc}, 22'h3f0080);
    nxt(); chk({sp, pc}, 22'h3e003c);
    nxt(); @(negedge ref_clk_i); chk({mb, rb}, 2'b11);
    nxt(); chk(pc, 14'h1200);
    chk(cf, 1'b0);
  endtask
  // Pair store at an even address, read back nibble by nibble
  task automatic t_pair();
    nxt(); nxt();
    nxt(); chk({ac, hl}, 12'h31b);
    nxt(); chk(ac, 4'h9);
    nxt(); chk({fo, cf}, 2'b10);
  endtask
  // ------------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ------------------------------------------------------------------
  initial begin
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    #(2000 * 100);
    bad_count++;
    end_sim();
  end
  initial begin
    for (int i = 0; i < 16384; i++) rom[i] = 8'hff;
    for (int i = 0; i < 32; i++) rom[i] = prog[i];
    rom[12'h060] = 8'hb5;
    rom[12'h0b5] = 8'h3c;
    {rom[12'h070], rom[12'h071], rom[12'h100], rom[12'h101]} = 32'he1005080;
    {rom[12'h080], rom[12'h03c], rom[12'h03d], rom[12'h03e]} = 32'haf1be200;
    {rom[14'h1200], rom[14'h1201], rom[14'h1202], rom[14'h1203], rom[14'h1204]} = 40'hc9635e4948;
    repeat (6) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    t_ptr();
    t_mem();
    t_aux();
    t_tab();
    t_flag();
    t_jump();
    t_pair();
    end_sim();
  end
endmodule
